// ### inc/ciot_defines.svh
// Offsets, field sizes, reset values and constants of the overlay bank.
`ifndef CIOT_DEFINES_SVH
`define CIOT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define CIOT_IDX_LCD_C0_BLUE  10'h076
`define CIOT_IDX_LCD_C0_GREEN 10'h077
`define CIOT_IDX_LCD_C0_RED   10'h078
`define CIOT_IDX_LCD_C1_BLUE  10'h07A
`define CIOT_IDX_LCD_C1_GREEN 10'h07B
`define CIOT_IDX_LCD_C1_RED   10'h07C
`define CIOT_IDX_LCD_THRESH   10'h07E
`define CIOT_IDX_CRT_C0_BLUE  10'h086
`define CIOT_IDX_CRT_C0_GREEN 10'h087
`define CIOT_IDX_CRT_C0_RED   10'h088
`define CIOT_IDX_CRT_C1_BLUE  10'h08A
`define CIOT_IDX_CRT_C1_GREEN 10'h08B
`define CIOT_IDX_CRT_C1_RED   10'h08C
`define CIOT_IDX_CRT_THRESH   10'h08E

// ----------------------------------------------------------------------
// Field sizes and reset values.
// ----------------------------------------------------------------------
`define CIOT_BLUE_W     5
`define CIOT_GREEN_W    6
`define CIOT_RED_W      5
`define CIOT_THR_W      4
`define CIOT_RST_BLUE   5'h00
`define CIOT_RST_GREEN  6'h00
`define CIOT_RST_RED    5'h00
`define CIOT_RST_THR    4'h0
`define CIOT_RST_PIXEL  16'h0000
`define CIOT_RST_DATA   32'h0000_0000

// ----------------------------------------------------------------------
// Overlay geometry and automatic threshold.
// ----------------------------------------------------------------------
`define CIOT_BPP        2
`define CIOT_CURSOR_DIM 64
`define CIOT_AUTO_THR   4'h8

`endif

// ### inc/ciot_pkg.sv
// Types shared by the overlay register bank and its pixel selector.
package ciot_pkg;

  typedef enum logic [1:0] {
    CIOT_F_BLUE  = 2'b00,
    CIOT_F_GREEN = 2'b01,
    CIOT_F_RED   = 2'b11,
    CIOT_F_THR   = 2'b10
  } ciot_field_t;

  typedef enum logic [1:0] {
    CIOT_PX_C0  = 2'b00,
    CIOT_PX_C1  = 2'b01,
    CIOT_PX_BG  = 2'b10,
    CIOT_PX_INV = 2'b11
  } ciot_code_t;

  typedef struct packed {
    logic        hit;
    logic        path;
    logic        col;
    ciot_field_t fld;
  } ciot_dec_t;

endpackage : ciot_pkg

// ### inc/ciot_ovl_if.sv
// Carrier of one display path's overlay colors to its pixel selector.
`timescale 1ns/10ps
interface ciot_ovl_if;
  logic [15:0] color0;
  logic [15:0] color1;
  modport src  (output color0, output color1);
  modport sink (input color0, input color1);
endinterface : ciot_ovl_if

// ### rtl/ciot_pixel_sel.sv
// Per-path overlay pixel selector driven by two-bit image codes.
`timescale 1ns/10ps
`include "ciot_defines.svh"
module ciot_pixel_sel
  import ciot_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 vld_i,
  input  wire logic [`CIOT_BPP-1:0] code_i,
  input  wire logic [15:0]          bg_i,
  ciot_ovl_if.sink                  ovl,
  output logic [15:0]               px_o,
  output logic                      vld_o
);

  logic [15:0] px_q;
  logic        vld_q;
  ciot_code_t  code;

  // The code is as wide as the overlay image depth.
  assign code = ciot_code_t'(code_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vld_q <= 1'b0;
    end else if (ce_i) begin
      vld_q <= vld_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      px_q <= `CIOT_RST_PIXEL;
    end else if (ce_i && vld_i) begin
      unique case (code)
        CIOT_PX_C0:  px_q <= ovl.color0;
        CIOT_PX_C1:  px_q <= ovl.color1;
        CIOT_PX_BG:  px_q <= bg_i;
        CIOT_PX_INV: px_q <= ~bg_i;
      endcase
    end
  end

  assign px_o  = px_q;
  assign vld_o = vld_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sel_c0;
    ce_i && vld_i && code_i == 2'b00 |=> px_o == $past(ovl.color0);
  endproperty
  a_sel_c0: assert property (p_sel_c0)
    else $error("Code 00 did not give color 0.");

  property p_sel_inv;
    ce_i && vld_i && code_i == 2'b11 |=> px_o == ~$past(bg_i);
  endproperty
  a_sel_inv: assert property (p_sel_inv)
    else $error("Code 11 did not give inverted background.");

endmodule : ciot_pixel_sel

// ### rtl/ciot_regs.sv
// Overlay color and fetch threshold register bank on classic Wishbone.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`include "ciot_defines.svh"
module ciot_regs
  import ciot_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        lcd_px_vld_i,
  input  wire logic [1:0]  lcd_px_code_i,
  input  wire logic [15:0] lcd_bg_i,
  output logic      [15:0] lcd_px_o,
  output logic             lcd_px_vld_o,
  input  wire logic        crt_px_vld_i,
  input  wire logic [1:0]  crt_px_code_i,
  input  wire logic [15:0] crt_bg_i,
  output logic      [15:0] crt_px_o,
  output logic             crt_px_vld_o,
  output logic      [3:0]  lcd_fifo_hi_o,
  output logic      [3:0]  crt_fifo_hi_o
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic ciot_dec_t ciot_decode(input logic [9:0] idx);
    ciot_dec_t d;
    d = '0;
    case (idx)
      `CIOT_IDX_LCD_C0_BLUE:  d = '{1'b1, 1'b0, 1'b0, CIOT_F_BLUE};
      `CIOT_IDX_LCD_C0_GREEN: d = '{1'b1, 1'b0, 1'b0, CIOT_F_GREEN};
      `CIOT_IDX_LCD_C0_RED:   d = '{1'b1, 1'b0, 1'b0, CIOT_F_RED};
      `CIOT_IDX_LCD_C1_BLUE:  d = '{1'b1, 1'b0, 1'b1, CIOT_F_BLUE};
      `CIOT_IDX_LCD_C1_GREEN: d = '{1'b1, 1'b0, 1'b1, CIOT_F_GREEN};
      `CIOT_IDX_LCD_C1_RED:   d = '{1'b1, 1'b0, 1'b1, CIOT_F_RED};
      `CIOT_IDX_LCD_THRESH:   d = '{1'b1, 1'b0, 1'b0, CIOT_F_THR};
      `CIOT_IDX_CRT_C0_BLUE:  d = '{1'b1, 1'b1, 1'b0, CIOT_F_BLUE};
      `CIOT_IDX_CRT_C0_GREEN: d = '{1'b1, 1'b1, 1'b0, CIOT_F_GREEN};
      `CIOT_IDX_CRT_C0_RED:   d = '{1'b1, 1'b1, 1'b0, CIOT_F_RED};
      `CIOT_IDX_CRT_C1_BLUE:  d = '{1'b1, 1'b1, 1'b1, CIOT_F_BLUE};
      `CIOT_IDX_CRT_C1_GREEN: d = '{1'b1, 1'b1, 1'b1, CIOT_F_GREEN};
      `CIOT_IDX_CRT_C1_RED:   d = '{1'b1, 1'b1, 1'b1, CIOT_F_RED};
      `CIOT_IDX_CRT_THRESH:   d = '{1'b1, 1'b1, 1'b0, CIOT_F_THR};
      default:                d = '0;
    endcase
    return d;
  endfunction : ciot_decode

  // A zero threshold hands the choice to hardware; the fixed fallback
  // keeps the fetch FIFO from ever being told to hold nothing.
  function automatic logic [3:0] ciot_eff_thr(input logic [3:0] thr);
    return (thr == `CIOT_RST_THR) ? `CIOT_AUTO_THR : thr;
  endfunction : ciot_eff_thr

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [`CIOT_BLUE_W-1:0]  blue_q  [2][2];
  logic [`CIOT_GREEN_W-1:0] green_q [2][2];
  logic [`CIOT_RED_W-1:0]   red_q   [2][2];
  logic [`CIOT_THR_W-1:0]   thr_q   [2];
  logic [3:0]               fifo_hi_q [2];
  logic [15:0]              col_w   [2][2];
  logic [3:0]               eff_w   [2];
  logic                     ack_q;
  logic [31:0]              dat_q;
  logic [31:0]              rd_d;
  ciot_dec_t                dec;
  logic                     wr_en;
  logic [4:0]               wr_lo5;
  logic [5:0]               wr_lo6;

  // Only the low byte lane carries register bits; a misaligned address
  // is treated as unmapped.
  always_comb begin
    dec = ciot_decode(wb_adr_i[11:2]);
    if (wb_adr_i[1:0] != 2'b00) begin
      dec.hit = 1'b0;
    end
  end

  // A write lands on the edge where the master sees ack.
  assign wr_en  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q
                & wb_sel_i[0] & dec.hit;
  assign wr_lo5 = wb_dat_i[4:0];
  assign wr_lo6 = wb_dat_i[5:0];

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  always_comb begin
    rd_d = `CIOT_RST_DATA;
    if (dec.hit) begin
      unique case (dec.fld)
        CIOT_F_BLUE:  rd_d[4:0] = blue_q[dec.path][dec.col];
        CIOT_F_GREEN: rd_d[5:0] = green_q[dec.path][dec.col];
        CIOT_F_RED:   rd_d[4:0] = red_q[dec.path][dec.col];
        CIOT_F_THR:   rd_d[3:0] = thr_q[dec.path];
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= `CIOT_RST_DATA;
    end else if (ce_i) begin
      dat_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------------
  // Color and threshold registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 2; p++) begin
        thr_q[p] <= `CIOT_RST_THR;
        for (int c = 0; c < 2; c++) begin
          blue_q[p][c]  <= `CIOT_RST_BLUE;
          green_q[p][c] <= `CIOT_RST_GREEN;
          red_q[p][c]   <= `CIOT_RST_RED;
        end
      end
    end else if (ce_i && wr_en) begin
      // Path and color index keep the four color sets apart.
      unique case (dec.fld)
        CIOT_F_BLUE:  blue_q[dec.path][dec.col]  <= wr_lo5;
        CIOT_F_GREEN: green_q[dec.path][dec.col] <= wr_lo6;
        CIOT_F_RED:   red_q[dec.path][dec.col]   <= wr_lo5;
        CIOT_F_THR:   thr_q[dec.path] <= wb_dat_i[3:0];
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Per-path overlay outputs
  // ----------------------------------------------------------------------
  ciot_ovl_if ovl_if [2] ();

  logic        px_vld_in [2];
  logic [1:0]  px_code_in [2];
  logic [15:0] bg_in [2];
  logic [15:0] px_out [2];
  logic        px_vld_out [2];

  assign px_vld_in[0]  = lcd_px_vld_i;
  assign px_vld_in[1]  = crt_px_vld_i;
  assign px_code_in[0] = lcd_px_code_i;
  assign px_code_in[1] = crt_px_code_i;
  assign bg_in[0]      = lcd_bg_i;
  assign bg_in[1]      = crt_bg_i;

  for (genvar g = 0; g < 2; g++) begin : g_path
    for (genvar c = 0; c < 2; c++) begin : g_col
      assign col_w[g][c] = {red_q[g][c], green_q[g][c], blue_q[g][c]};
    end

    assign ovl_if[g].color0 = col_w[g][0];
    assign ovl_if[g].color1 = col_w[g][1];

    // Each path reads only its own threshold register.
    assign eff_w[g] = ciot_eff_thr(thr_q[g]);

    // One register stage: a new value steers the next fetch decision.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        fifo_hi_q[g] <= `CIOT_AUTO_THR;
      end else if (ce_i) begin
        fifo_hi_q[g] <= eff_w[g];
      end
    end

    ciot_pixel_sel u_sel (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .vld_i  (px_vld_in[g]),
      .code_i (px_code_in[g]),
      .bg_i   (bg_in[g]),
      .ovl    (ovl_if[g].sink),
      .px_o   (px_out[g]),
      .vld_o  (px_vld_out[g])
    );
  end

  assign lcd_px_o      = px_out[0];
  assign lcd_px_vld_o  = px_vld_out[0];
  assign crt_px_o      = px_out[1];
  assign crt_px_vld_o  = px_vld_out[1];
  assign lcd_fifo_hi_o = fifo_hi_q[0];
  assign crt_fifo_hi_o = fifo_hi_q[1];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A low clock enable legally stretches ack, so only a running edge counts.
  property p_ack_drop;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("Ack stood for more than one cycle.");

  property p_freeze;
    !ce_i |=> $stable(wb_ack_o) && $stable(lcd_fifo_hi_o)
      && $stable(crt_fifo_hi_o) && $stable(lcd_px_o) && $stable(lcd_px_vld_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved while the clock enable was low.");

  property p_rd_upper;
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:6] == 26'h000_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("Unused read bits were not zero.");

  property p_lcd_c0_wr;
    ce_i && wr_en && !dec.path && !dec.col && dec.fld == CIOT_F_BLUE
      |=> col_w[0][0][4:0] == $past(wr_lo5);
  endproperty
  a_lcd_c0_wr: assert property (p_lcd_c0_wr)
    else $error("LCD color 0 blue write lost.");

  property p_lcd_c1_iso;
    ce_i && wr_en && !dec.path && dec.col |=> $stable(col_w[0][0]);
  endproperty
  a_lcd_c1_iso: assert property (p_lcd_c1_iso)
    else $error("LCD color 1 write disturbed color 0.");

  property p_crt_c0_wr;
    ce_i && wr_en && dec.path && !dec.col && dec.fld == CIOT_F_GREEN
      |=> col_w[1][0][10:5] == $past(wr_lo6) && $stable(col_w[0][0]);
  endproperty
  a_crt_c0_wr: assert property (p_crt_c0_wr)
    else $error("CRT color 0 green write wrong.");

  property p_crt_c1_iso;
    ce_i && wr_en && dec.path && dec.col |=> $stable(col_w[0][1]);
  endproperty
  a_crt_c1_iso: assert property (p_crt_c1_iso)
    else $error("CRT color 1 write disturbed LCD color 1.");

  property p_thr_nz;
    lcd_fifo_hi_o != 4'h0 && crt_fifo_hi_o != 4'h0;
  endproperty
  a_thr_nz: assert property (p_thr_nz)
    else $error("FIFO high threshold output was zero.");

  property p_lcd_thr;
    ce_i |=> lcd_fifo_hi_o == $past(eff_w[0]);
  endproperty
  a_lcd_thr: assert property (p_lcd_thr)
    else $error("LCD threshold not from LCD register.");

  property p_crt_thr;
    ce_i |=> crt_fifo_hi_o == $past(eff_w[1]);
  endproperty
  a_crt_thr: assert property (p_crt_thr)
    else $error("CRT threshold not from CRT register.");

  property p_auto;
    ce_i && thr_q[0] == 4'h0 |=> lcd_fifo_hi_o == `CIOT_AUTO_THR;
  endproperty
  a_auto: assert property (p_auto)
    else $error("Zero threshold did not select automatic value.");

  property p_direct;
    ce_i && thr_q[1] != 4'h0 |=> crt_fifo_hi_o == $past(thr_q[1]);
  endproperty
  a_direct: assert property (p_direct)
    else $error("Nonzero threshold not used directly.");

  c_write: cover property (ce_i && wr_en);
  c_read:  cover property (wb_ack_o && !wb_we_i && dec.hit);
  c_auto:  cover property (ce_i && thr_q[1] == 4'h0 ##1 thr_q[1] != 4'h0);
  c_inv:   cover property (lcd_px_vld_i && lcd_px_code_i == 2'b11);

endmodule : ciot_regs

// ### test/ciot_host_model.sv
// Host side model that issues classic Wishbone single cycles.
`timescale 1ns/10ps
module ciot_host_model (
  input  wire logic        clk_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [11:0] adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 12'h000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // --------------------
  // One bus cycle.
  // --------------------
  // Released lines are inverted so a stale value never passes for a live one.
  task automatic xfer(input logic we, input logic [11:0] adr,
                      input logic [3:0] sel, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= adr;
    sel_o <= sel;
    dat_o <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    rd = dat_i;
    ok = (ack_i === 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= ~we;
    adr_o <= ~adr;
    sel_o <= ~sel;
    dat_o <= ~wd;
  endtask : xfer
endmodule : ciot_host_model

// ### test/test_ciot_regs.sv
// Self-checking bench for the overlay color and threshold bank.
`timescale 1ns/10ps
`include "ciot_defines.svh"
module test_ciot_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc, stb, we, lv, cv, ack, lvo, cvo;
  logic [11:0] adr;
  logic [3:0] sel, lth, cth;
  logic [31:0] wdat, rdat, r;
  logic [1:0] lc = 2'b00;
  logic [1:0] cc = 2'b00;
  logic [15:0] lbg = 16'h0000;
  logic [15:0] cbg = 16'h0000;
  logic [15:0] lpx, cpx, e;
  int errors = 0;
  int cmp_count = 0;
  logic [9:0] idx [14] = '{`CIOT_IDX_LCD_C0_BLUE, `CIOT_IDX_LCD_C0_GREEN,
    `CIOT_IDX_LCD_C0_RED, `CIOT_IDX_LCD_C1_BLUE, `CIOT_IDX_LCD_C1_GREEN,
    `CIOT_IDX_LCD_C1_RED, `CIOT_IDX_LCD_THRESH, `CIOT_IDX_CRT_C0_BLUE,
    `CIOT_IDX_CRT_C0_GREEN, `CIOT_IDX_CRT_C0_RED, `CIOT_IDX_CRT_C1_BLUE,
    `CIOT_IDX_CRT_C1_GREEN, `CIOT_IDX_CRT_C1_RED, `CIOT_IDX_CRT_THRESH};
  logic [7:0] msk [14] = '{8'h1F, 8'h3F, 8'h1F, 8'h1F, 8'h3F, 8'h1F, 8'h0F,
    8'h1F, 8'h3F, 8'h1F, 8'h1F, 8'h3F, 8'h1F, 8'h0F};
  logic [7:0] ev [14];

  initial lv = 1'b0;
  initial cv = 1'b0;
  always #50 clk_i = ~clk_i;

  ciot_host_model ciot_host_model_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat),
    .ack_i(ack));

  ciot_regs ciot_regs_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .lcd_px_vld_i(lv), .lcd_px_code_i(lc), .lcd_bg_i(lbg), .lcd_px_o(lpx),
    .lcd_px_vld_o(lvo), .crt_px_vld_i(cv), .crt_px_code_i(cc),
    .crt_bg_i(cbg), .crt_px_o(cpx), .crt_px_vld_o(cvo),
    .lcd_fifo_hi_o(lth), .crt_fifo_hi_o(cth));

  // --------------------
  // Shared tasks.
  // --------------------
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    logic ok;
    ciot_host_model_i.xfer(w, a, s, d, r, ok);
    if (!ok) begin
      errors++;
      conclude();
    end
  endtask : bus

  function automatic logic [15:0] col(input int base);
    return {ev[base+2][4:0], ev[base+1][5:0], ev[base][4:0]};
  endfunction : col

  task automatic pix(input logic crt, input logic [1:0] c,
                     input logic [15:0] bg, input logic [15:0] exp);
    @(posedge clk_i);
    if (crt) begin
      cv <= 1'b1;
      cc <= c;
      cbg <= bg;
    end else begin
      lv <= 1'b1;
      lc <= c;
      lbg <= bg;
    end
    @(posedge clk_i);
    lv <= 1'b0;
    cv <= 1'b0;
    #1;
    check(32'(crt ? cpx : lpx), 32'(exp));
    check(32'({lvo, cvo}), crt ? 32'h0000_0001 : 32'h0000_0002);
  endtask : pix

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      bus(1'b0, {idx[i], 2'b00}, 32'h0000_0000, 4'hF);
      check(r, 32'h0000_0000);
      ev[i] = (8'h35 + 8'(i) * 8'h0B) & msk[i];
    end
    check(32'({lth, cth}), 32'h0000_0088);
    $display("reset test done");
    for (int i = 0; i < 14; i++)
      bus(1'b1, {idx[i], 2'b00}, {24'hFFFF_FF, 8'h35 + 8'(i) * 8'h0B}, 4'h1);
    for (int i = 0; i < 14; i++) begin
      bus(1'b0, {idx[i], 2'b00}, 32'h0000_0000, 4'hF);
      check(r, 32'(ev[i]));
    end
    repeat (2) @(posedge clk_i);
    check(32'(lth), 32'(ev[6][3:0]));
    check(32'(cth), 32'(ev[13][3:0]));
    $display("register test done");
    for (int p = 0; p < 2; p++) begin
      pix(p[0], 2'b00, 16'hA5C3, col(p * 7));
      pix(p[0], 2'b01, 16'hA5C3, col(p * 7 + 3));
      pix(p[0], 2'b10, 16'h1E2D, 16'h1E2D);
      pix(p[0], 2'b11, 16'h1E2D, 16'hE1D2);
    end
    $display("pixel test done");
    bus(1'b1, {idx[6], 2'b00}, 32'h0000_0000, 4'h1);
    bus(1'b1, {idx[13], 2'b00}, 32'h0000_000F, 4'h1);
    repeat (2) @(posedge clk_i);
    check(32'({lth, cth}), 32'h0000_008F);
    ev[2] = 8'h1F;
    bus(1'b1, {idx[2], 2'b00}, 32'h0000_001F, 4'h1);
    pix(1'b0, 2'b00, 16'h0000, col(0));
    $display("threshold test done");
    bus(1'b1, {idx[0], 2'b01}, 32'h0000_0000, 4'h1);
    bus(1'b1, {idx[0], 2'b00}, 32'h0000_0000, 4'hE);
    bus(1'b0, {idx[0], 2'b00}, 32'h0000_0000, 4'hF);
    check(r, 32'(ev[0]));
    bus(1'b0, 12'h000, 32'h0000_0000, 4'hF);
    check(r, 32'h0000_0000);
    $display("refusal test done");
    // A code offered while the enable is low must not be taken.
    ce_i <= 1'b0;
    lv   <= 1'b1;
    lc   <= 2'b01;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    lv   <= 1'b0;
    #1;
    check(32'(lpx), 32'(col(0)));
    check(32'(lvo), 32'h0000_0000);
    $display("freeze test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, {idx[12], 2'b00}, 32'h0000_0000, 4'hF);
    check(r, 32'h0000_0000);
    check(32'({lth, cth}), 32'h0000_0088);
    $display("second reset test done");
    conclude();
  end
endmodule : test_ciot_regs
